/* File: src/plsr_top.sv */
`timescale 1ns/1ps
module plsr_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Management register access
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    // Port line status
    input wire logic [3:0] link_fail,
    input wire logic [3:0] polarity_bad,
    input wire logic [3:0] jabber,
    input wire logic led_normal_mode,
    // Outputs to LED and port logic
    output logic [3:0] status_led,
    output logic [3:0] link_detect_disable,
    output logic link_jabber_irq,
    output logic polarity_auto_correct_enable,
    output logic heartbeat_enable
);
    logic [15:0] glob;
    logic [15:0] next_glob;
    logic [15:0] rdq;
    logic [15:0] next_rdq;
    logic [3:0] ledq;
    logic [3:0] disq;
    logic [3:0] evt;
    logic [3:0] jab;
    logic [15:0] prd [plsr_pkg::plsr_ports];
    logic irq;
    logic next_irq;
    logic sel_glob;
    logic [3:0] sel_port;
    logic glob_wr;
    logic glob_rd;
    logic [3:0] port_wr;
    logic any_event;

    // ****************************************
    // Per-port banks
    // ****************************************
    for (genvar i = 0; i < plsr_pkg::plsr_ports; i++) begin : g_port
        plsr_port_if pif ();
        assign pif.wr = port_wr[i];
        assign pif.wdata = mgmt_wdata;
        assign pif.link_fail = link_fail[i];
        assign pif.polarity_bad = polarity_bad[i];
        assign pif.jabber = jabber[i];
        assign pif.led_normal_mode = led_normal_mode;
        assign prd[i] = pif.rdata;
        assign ledq[i] = pif.status_led;
        assign evt[i] = pif.link_change;
        assign jab[i] = pif.rdata[plsr_pkg::plsr_bit_jab];
        assign disq[i] = pif.rdata[plsr_pkg::plsr_bit_link_off];
        plsr_port_bank u_bank (
            .mclk(mclk),
            .nrst(nrst),
            .pif(pif)
        );
    end

    // ****************************************
    // Address decode
    // ****************************************
    // One decode feeds both strobes, so a write and a read never disagree on the target.
    always_comb begin
        sel_glob = (mgmt_addr == plsr_pkg::plsr_addr_global);
        sel_port = 4'h0;
        for (int k = 0; k < plsr_pkg::plsr_ports; k++) begin
            sel_port[k] = (mgmt_addr == plsr_pkg::plsr_addr_port0 + 5'(k));
        end
        glob_wr = mgmt_wr && sel_glob;
        glob_rd = mgmt_rd && sel_glob;
        port_wr = {4{mgmt_wr}} & sel_port;
    end

    // ****************************************
    // Event gathering
    // ****************************************
    // R10 any port event
    assign any_event = (|evt) || (|jab);

    // ****************************************
    // Global control and mask register
    // ****************************************
    always_comb begin
        next_glob = glob;
        if (glob_wr) begin
            next_glob = (mgmt_wdata & plsr_pkg::plsr_glob_wmask)
                | (glob & ~plsr_pkg::plsr_glob_wmask);
        end
        // R10 read clears, event wins
        if (glob_rd) begin
            next_glob[plsr_pkg::plsr_bit_irq] = 1'b0;
        end
        if (any_event) begin
            next_glob[plsr_pkg::plsr_bit_irq] = 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            glob <= plsr_pkg::plsr_glob_reset;
        end else begin
            glob <= next_glob;
        end
    end

    // ****************************************
    // Interrupt pin
    // ****************************************
    // Mask bit high blocks the pin while the flag still records, so polling keeps working.
    always_comb begin
        next_irq = next_glob[plsr_pkg::plsr_bit_irq] & ~next_glob[plsr_pkg::plsr_bit_imask];
    end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // The answer is held until the next read, so a slow station may sample it late.
    always_comb begin
        next_rdq = rdq;
        if (mgmt_rd) begin
            next_rdq = 16'h0000;
            if (sel_glob) begin
                next_rdq = glob;
            end
            for (int k = 0; k < plsr_pkg::plsr_ports; k++) begin
                if (sel_port[k]) begin
                    next_rdq = prd[k];
                end
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdq <= 16'h0000;
        end else begin
            rdq <= next_rdq;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Every output below is a register bit, so no decode glitch reaches a pin.
    assign mgmt_rdata = rdq;
    assign status_led = ledq;
    assign link_detect_disable = disq;
    assign link_jabber_irq = irq;
    assign polarity_auto_correct_enable = glob[plsr_pkg::plsr_bit_polsw];
    assign heartbeat_enable = glob[plsr_pkg::plsr_bit_hb];
endmodule : plsr_top

/* File: src/plsr_pkg.sv */
// Notes on behaviour
// R1: Error LED bit set drives that port's status LED solid; clear restores normal.
// R2: Error LED bit is a visual prompt only; no data-path effect.
// R3: Forced LED takes effect only in normal LED mode.
// R4: Polarity flag follows detected reversed polarity; resets to one; writes ignored.
// R5: Management trusts polarity flag only when auto correct enable is set.
// R6: Link fail flag is one in link-fail state, zero when good; resets one.
// R7: First port link flag reports twisted pair link even in attachment unit mode.
// R8: Link detect disable forces link fail flag zero; disable resets zero.
// R9: Jabber flag follows jabber condition; resets zero; writes ignored.
// R10: Link change or jabber sets global irq flag; register read clears it.
package plsr_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] plsr_addr_global = 5'h08;
    localparam logic [4:0] plsr_addr_port0 = 5'h10;
    localparam int plsr_ports = 4;
    // ****************************************
    // Port register fields
    // ****************************************
    localparam int plsr_bit_link_off = 8;
    localparam int plsr_bit_err = 7;
    localparam int plsr_bit_pol = 2;
    localparam int plsr_bit_link = 1;
    localparam int plsr_bit_jab = 0;
    localparam logic [15:0] plsr_port_wmask = 16'hff80;
    localparam logic [15:0] plsr_port_reset = 16'h0806;
    // ****************************************
    // Global register fields
    // ****************************************
    localparam int plsr_bit_irq = 13;
    localparam int plsr_bit_autosw = 12;
    localparam int plsr_bit_port_mode = 11;
    localparam int plsr_bit_hb = 10;
    localparam int plsr_bit_polsw = 9;
    localparam int plsr_bit_led_ctl = 2;
    localparam int plsr_bit_imask = 1;
    localparam int plsr_bit_rx_gate = 0;
    localparam logic [15:0] plsr_glob_wmask = 16'h1fc7;
    localparam logic [15:0] plsr_glob_reset = 16'h1600;
endpackage : plsr_pkg

/* File: src/plsr_port_if.sv */
`timescale 1ns/1ps
interface plsr_port_if;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic link_fail;
    logic polarity_bad;
    logic jabber;
    logic led_normal_mode;
    logic status_led;
    logic link_change;
    modport bank (input wr, input wdata, output rdata, input link_fail, input polarity_bad,
        input jabber, input led_normal_mode, output status_led, output link_change);
    modport top (output wr, output wdata, input rdata, output link_fail, output polarity_bad,
        output jabber, output led_normal_mode, input status_led, input link_change);
endinterface : plsr_port_if

/* File: src/plsr_port_bank.sv */
`timescale 1ns/1ps
module plsr_port_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Bundle
    plsr_port_if.bank pif
);
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic led;
    logic next_led;
    logic link_q;
    logic next_link_q;
    logic link_eff;

    // ****************************************
    // Control and flags
    // ****************************************
    // R8 forced good link
    assign link_eff = pif.link_fail & ~ctrl[plsr_pkg::plsr_bit_link_off];
    always_comb begin
        next_ctrl = ctrl;
        if (pif.wr) begin
            next_ctrl = pif.wdata & plsr_pkg::plsr_port_wmask;
        end
        // R4 polarity flag
        next_ctrl[plsr_pkg::plsr_bit_pol] = pif.polarity_bad;
        // R6 R7 link flag
        next_ctrl[plsr_pkg::plsr_bit_link] = link_eff;
        // R9 jabber flag
        next_ctrl[plsr_pkg::plsr_bit_jab] = pif.jabber;
        next_link_q = link_eff;
        // R1 R3 forced LED; R2 no data-path use.
        next_led = ctrl[plsr_pkg::plsr_bit_err] & pif.led_normal_mode;
    end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl <= plsr_pkg::plsr_port_reset;
            link_q <= 1'b1;
            led <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            link_q <= next_link_q;
            led <= next_led;
        end
    end
    assign pif.rdata = ctrl;
    assign pif.status_led = led;
    assign pif.link_change = link_q ^ link_eff;
endmodule : plsr_port_bank

/* File: bench/plsr_top_props.sv */
`timescale 1ns/1ps
module plsr_top_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Watched ports
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic [3:0] jabber,
    input wire logic led_normal_mode,
    input wire logic [3:0] status_led,
    input wire logic [3:0] link_detect_disable,
    input wire logic polarity_auto_correct_enable,
    input wire logic heartbeat_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence err_set_s;
        mgmt_wr && mgmt_addr == 5'h10 && mgmt_wdata[7] && led_normal_mode;
    endsequence
    AST_LED_ON: assert property (err_set_s ##1 led_normal_mode [*2] |-> status_led[0])
        else $error("status led not forced on");
    AST_LED_OFF: assert property (!led_normal_mode |=> status_led == 4'h0)
        else $error("status led on outside normal mode");
    AST_DIS: assert property (mgmt_wr && mgmt_addr == 5'h10 |=>
        link_detect_disable[0] == $past(mgmt_wdata[8])) else $error("disable bit wrong");
    AST_LINK: assert property (mgmt_rd && mgmt_addr == 5'h10 && link_detect_disable[0]
        && $past(link_detect_disable[0]) |=> !mgmt_rdata[1]) else $error("link flag not zero");
    AST_JAB: assert property (mgmt_rd && mgmt_addr == 5'h12 && jabber[2] == $past(jabber[2])
        |=> mgmt_rdata[0] == $past(jabber[2])) else $error("jabber flag wrong");
    AST_UNMAP: assert property (mgmt_rd && mgmt_addr == 5'h1f |=> mgmt_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_GLOB: assert property (mgmt_wr && mgmt_addr == 5'h08 |=>
        polarity_auto_correct_enable == $past(mgmt_wdata[9])
        && heartbeat_enable == $past(mgmt_wdata[10])) else $error("global bits wrong");
    AST_HOLD: assert property (!$past(mgmt_rd) |-> $stable(mgmt_rdata))
        else $error("read data moved without read");
endmodule : plsr_top_props
bind plsr_top plsr_top_props u_props (.mclk, .nrst, .mgmt_wr, .mgmt_rd, .mgmt_addr,
    .mgmt_wdata, .mgmt_rdata, .jabber, .led_normal_mode, .status_led, .link_detect_disable,
    .polarity_auto_correct_enable, .heartbeat_enable);

/* File: bench/plsr_mgmt_model.sv */
`timescale 1ns/1ps
module plsr_mgmt_model (
    // Clock
    input wire logic mclk,
    // Requests
    output logic mgmt_wr = 1'b0,
    output logic mgmt_rd = 1'b0,
    output logic [4:0] mgmt_addr = 5'h00,
    output logic [15:0] mgmt_wdata = 16'h0000,
    // Answer
    input wire logic [15:0] mgmt_rdata
);
    // Released address and data lines show the inverse and both strobes drop low, so a stale value never looks valid.
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
            output logic [15:0] q);
        @(posedge mclk);
        {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} <= {w, !w, a, d};
        @(posedge mclk);
        {mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata} <= {2'b00, ~a, ~d};
        @(posedge mclk);
        q = mgmt_rdata;
    endtask : xfer
endmodule : plsr_mgmt_model

/* File: bench/port_link_status_register_tb_top.sv */
`timescale 1ns/1ps
module port_link_status_register_tb_top;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] link_fail = 4'hf;
    logic [3:0] polarity_bad = 4'hf;
    logic [3:0] jabber = 4'h0;
    logic led_normal_mode = 1'b1;
    logic mgmt_wr, mgmt_rd, irq, pae, hb;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, q;
    logic [3:0] status_led, link_detect_disable;
    int fails = 0;
    int samples_checked = 0;
    logic [36:0] rows [7] = '{{5'h08, 16'hffff, 16'h1fc7}, {5'h08, 16'h1600, 16'h1600},
        {5'h10, 16'h0180, 16'h0180}, {5'h11, 16'h0878, 16'h0800},
        {5'h12, 16'h0807, 16'h0800}, {5'h13, 16'h0080, 16'h0080}, {5'h1f, 16'hffff, 16'h0000}};
    always #12.5 mclk = ~mclk;
    plsr_mgmt_model u_mgmt (.mclk, .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata, .mgmt_rdata);
    plsr_top u_dut (.mclk, .nrst, .mgmt_wr, .mgmt_rd, .mgmt_addr, .mgmt_wdata, .mgmt_rdata,
        .link_fail, .polarity_bad, .jabber, .led_normal_mode, .status_led,
        .link_detect_disable, .link_jabber_irq(irq), .polarity_auto_correct_enable(pae),
        .heartbeat_enable(hb));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checked %0d wrong %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        u_mgmt.xfer(1'b0, a, 16'h0000, q);
        check(q, exp);
    endtask : rd
    initial begin
        repeat (2000) @(posedge mclk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1 check({13'h0000, irq, pae, hb}, 16'h0003);
        rd(5'h10, 16'h0806);
        rd(5'h08, 16'h1600);
        @(posedge mclk);
        {link_fail, polarity_bad, jabber} <= 12'h004;
        repeat (3) @(posedge mclk);
        #1 check(16'(irq), 16'h0001);
        rd(5'h12, 16'h0801);
        @(posedge mclk);
        jabber <= 4'h0;
        rd(5'h08, 16'h3600);
        rd(5'h08, 16'h1600);
        #1 check(16'(irq), 16'h0000);
        $display("reset and irq test done");
        for (int i = 0; i < 7; i++) begin
            u_mgmt.xfer(1'b1, rows[i][36:32], rows[i][31:16], q);
            rd(rows[i][36:32], rows[i][15:0]);
        end
        $display("row test done");
        #1 check(16'(link_detect_disable), 16'h0001);
        #1 check(16'(status_led), 16'h0009);
        @(posedge mclk);
        led_normal_mode <= 1'b0;
        repeat (3) @(posedge mclk);
        #1 check(16'(status_led), 16'h0000);
        u_mgmt.xfer(1'b1, 5'h10, 16'h0800, q);
        u_mgmt.xfer(1'b1, 5'h08, 16'h0600, q);
        {led_normal_mode, link_fail} <= 5'h11;
        rd(5'h10, 16'h0802);
        #1 check(16'(status_led), 16'h0008);
        u_mgmt.xfer(1'b1, 5'h10, 16'h0100, q);
        rd(5'h10, 16'h0100);
        $display("led and attachment unit test done");
        finish_test();
    end
endmodule : port_link_status_register_tb_top
